/* File: hdl/i2c_rate_map.svh */
// offsets, field positions, reset values and table constants
`ifndef I2C_RATE_MAP_SVH
`define I2C_RATE_MAP_SVH

// register indices; byte address is four times the index
`define OWN_ADDR_IDX      14'h3070
`define RATE_DIV_IDX      14'h3071
`define LINE_STAT_IDX     14'h3080

// reset values
`define OWN_ADDR_RST      7'h00
`define RATE_DIV_RST      8'h00

// own address field
`define OWN_ADDR_MSB      7
`define OWN_ADDR_LSB      1

// bit-rate divider fields
`define SCALE_MSB         7
`define SCALE_LSB         6
`define RATE_IDX_MSB      5
`define RATE_IDX_LSB      0

// scale codes
`define SCALE_X1          2'b00
`define SCALE_X2          2'b01
`define SCALE_X4          2'b10

// status bits
`define STAT_BUSY_BIT     0
`define STAT_MATCH_BIT    1
`define STAT_RX_BIT       2
`define STAT_OWN_BIT      3

// divider lookup generator constants
`define DIV_BASE          12'h014
`define SDA_HOLD_BASE     10'h007
`define START_HOLD_TRIM   10'h004
`define STOP_HOLD_EXTRA   10'h001

`endif

/* File: hdl/i2c_rate_pkg.sv */
// types shared by the own-address and bit-rate block
package i2c_rate_pkg;

   typedef enum logic [1:0] {
      CMD_START,
      CMD_STOP,
      CMD_BIT
   } line_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOW_HOLD,
      ST_LOW_REST,
      ST_HIGH_WAIT,
      ST_HIGH,
      ST_START_HOLD
   } line_state_t;

endpackage

/* File: hdl/i2c_rate_table.sv */
// clock-rate index to divider and hold value lookup
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rate_map.svh"

module i2c_rate_table (
   // index
   input  wire logic [5:0]  clock_rate_index_i,
   // looked-up values
   output logic      [11:0] scl_div_o,
   output logic      [9:0]  sda_hold_o,
   output logic      [9:0]  start_hold_o,
   output logic      [9:0]  stop_hold_o
);

   logic [11:0] div;

   // fixed, monotonic table; data and start holds are below half a period, stop hold is one above it
   always_comb begin
      div          = `DIV_BASE + {3'h0, clock_rate_index_i, 3'h0};
      scl_div_o    = div;
      sda_hold_o   = `SDA_HOLD_BASE + {4'h0, clock_rate_index_i};
      start_hold_o = div[10:1] - `START_HOLD_TRIM;
      stop_hold_o  = div[10:1] + `STOP_HOLD_EXTRA;
   end

endmodule
`default_nettype wire

/* File: hdl/i2c_own_address_and_bit_rate.sv */
// own target address and bit-rate timing of the two-wire controller
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rate_map.svh"

module i2c_own_address_and_bit_rate
   import i2c_rate_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [15:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // address compare
   input  wire logic        cmp_req_i,
   input  wire logic        cmp_ten_bit_i,
   input  wire logic        cmp_upper_ok_i,
   input  wire logic [6:0]  cmp_addr_i,
   output logic             match_o,
   output logic             match_valid_o,
   // line commands
   input  wire logic        cmd_valid_i,
   input  wire logic [1:0]  cmd_i,
   input  wire logic        cmd_bit_i,
   output logic             cmd_ready_o,
   output logic             rx_valid_o,
   output logic             rx_bit_o,
   // open-drain pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   output logic             sda_o,
   output logic             sda_oe_n_o
);

   // ---------------- pin synchronisers ----------------
   logic [1:0] pin_in;
   logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   assign pin_in = {sda_i, scl_i};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_comb begin
            filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_q[g]   <= 1'b1;
               s2_q[g]   <= 1'b1;
               s3_q[g]   <= 1'b1;
               filt_q[g] <= 1'b1;
            end else begin
               s1_q[g]   <= pin_in[g];
               s2_q[g]   <= s1_q[g];
               s3_q[g]   <= s2_q[g];
               filt_q[g] <= filt_d[g];
            end
         end
      end
   endgenerate

   logic scl_f, sda_f;
   assign scl_f = filt_q[0];
   assign sda_f = filt_q[1];

   // ---------------- register bank ----------------
   logic [7:1]  own_q, own_d;
   logic [7:0]  rate_q, rate_d;
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic        match_q, match_d, mval_q, mval_d;
   logic        busy, own_bus_q, own_bus_d, rx_bit_q, rx_bit_d;
   logic [13:0] idx;
   assign idx = adr_i[15:2];

   always_comb begin
      ack_d   = cyc_i & stb_i & ~ack_q;
      dat_d   = 32'h0000_0000;
      own_d   = own_q;
      rate_d  = rate_q;
      match_d = match_q;
      mval_d  = 1'b0;
      if (ack_d && we_i && sel_i[0]) begin
         if (idx == `OWN_ADDR_IDX) begin
            own_d = dat_i[`OWN_ADDR_MSB:`OWN_ADDR_LSB];
         end
         if (idx == `RATE_DIV_IDX) begin
            rate_d = dat_i[7:0];
         end
      end
      if (ack_d && !we_i) begin
         case (idx)
            `OWN_ADDR_IDX:  dat_d[7:0] = {own_q, 1'b0};
            `RATE_DIV_IDX:  dat_d[7:0] = rate_q;
            `LINE_STAT_IDX: begin
               dat_d[`STAT_BUSY_BIT]  = busy;
               dat_d[`STAT_MATCH_BIT] = match_q;
               dat_d[`STAT_RX_BIT]    = rx_bit_q;
               dat_d[`STAT_OWN_BIT]   = own_bus_q;
            end
            default:        dat_d = 32'h0000_0000;
         endcase
      end
      if (cmp_req_i) begin
         // full address, or low seven bits of a 10-bit one
         match_d = (cmp_addr_i == own_q)
                   && (!cmp_ten_bit_i || cmp_upper_ok_i);
         mval_d  = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_q   <= `OWN_ADDR_RST;
         rate_q  <= `RATE_DIV_RST;
         ack_q   <= 1'b0;
         dat_q   <= 32'h0000_0000;
         match_q <= 1'b0;
         mval_q  <= 1'b0;
      end else begin
         own_q   <= own_d;
         rate_q  <= rate_d;
         ack_q   <= ack_d;
         dat_q   <= dat_d;
         match_q <= match_d;
         mval_q  <= mval_d;
      end
   end

   // ---------------- rate and hold cycles ----------------
   logic [11:0] scl_div;
   logic [9:0]  sda_hold, start_hold, stop_hold;
   logic [1:0]  shift;
   logic [15:0] period_c, half_c, sda_c, start_c, stop_c, rest_c;

   i2c_rate_table u_table (
      .clock_rate_index_i (rate_q[`RATE_IDX_MSB:`RATE_IDX_LSB]),
      .scl_div_o          (scl_div),
      .sda_hold_o         (sda_hold),
      .start_hold_o       (start_hold),
      .stop_hold_o        (stop_hold)
   );

   always_comb begin
      case (rate_q[`SCALE_MSB:`SCALE_LSB])
         `SCALE_X1: shift = 2'd0;
         `SCALE_X2: shift = 2'd1;
         `SCALE_X4: shift = 2'd2;
         default:   shift = 2'd0;
      endcase
      period_c = {4'h0, scl_div} << shift;
      half_c   = period_c >> 1;
      sda_c    = {6'h00, sda_hold} << shift;
      start_c  = {6'h00, start_hold} << shift;
      stop_c   = {6'h00, stop_hold} << shift;
      rest_c   = (half_c > sda_c) ? half_c - sda_c : 16'h0001;
   end

   // ---------------- line engine ----------------
   line_state_t st_q, st_d;
   line_cmd_t   op_q, op_d;
   logic [15:0] cnt_q, cnt_d;
   logic        bit_q, bit_d, done, data_bit;
   logic        scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
   logic        ready_q, ready_d, rxv_q, rxv_d;

   assign done = (cnt_q == 16'h0001);
   assign busy = (st_q != ST_IDLE);

   always_comb begin
      st_d       = st_q;
      op_d       = op_q;
      bit_d      = bit_q;
      cnt_d      = (cnt_q > 16'h0001) ? cnt_q - 16'h0001 : cnt_q;
      scl_oe_n_d = scl_oe_n_q;
      sda_oe_n_d = sda_oe_n_q;
      own_bus_d  = own_bus_q;
      rx_bit_d   = rx_bit_q;
      rxv_d      = 1'b0;
      data_bit   = 1'b1;
      case (op_q)
         CMD_BIT:  data_bit = bit_q;
         CMD_STOP: data_bit = 1'b0;
         default:  data_bit = 1'b1;
      endcase
      case (st_q)
         ST_IDLE: begin
            if (cmd_valid_i && ready_q) begin
               op_d  = line_cmd_t'(cmd_i);
               bit_d = cmd_bit_i;
               if (cmd_i == CMD_START && !own_bus_q) begin
                  sda_oe_n_d = 1'b0;
                  cnt_d      = start_c;
                  st_d       = ST_START_HOLD;
               end else if (own_bus_q) begin
                  cnt_d = sda_c;
                  st_d  = ST_LOW_HOLD;
               end
            end
         end
         ST_LOW_HOLD: begin
            if (done) begin
               sda_oe_n_d = data_bit;
               cnt_d      = rest_c;
               st_d       = ST_LOW_REST;
            end
         end
         ST_LOW_REST: begin
            if (done) begin
               scl_oe_n_d = 1'b1;
               st_d       = ST_HIGH_WAIT;
            end
         end
         ST_HIGH_WAIT: begin
            // wait out any clock stretching by the far end
            if (scl_f) begin
               cnt_d = (op_q == CMD_STOP) ? stop_c : half_c;
               st_d  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (done) begin
               case (op_q)
                  CMD_BIT: begin
                     rx_bit_d   = sda_f;
                     rxv_d      = 1'b1;
                     scl_oe_n_d = 1'b0;
                     st_d       = ST_IDLE;
                  end
                  CMD_STOP: begin
                     sda_oe_n_d = 1'b1;
                     own_bus_d  = 1'b0;
                     st_d       = ST_IDLE;
                  end
                  default: begin
                     sda_oe_n_d = 1'b0;
                     cnt_d      = start_c;
                     st_d       = ST_START_HOLD;
                  end
               endcase
            end
         end
         ST_START_HOLD: begin
            if (done) begin
               scl_oe_n_d = 1'b0;
               own_bus_d  = 1'b1;
               st_d       = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      ready_d = (st_d == ST_IDLE) && !(cmd_valid_i && ready_q);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q       <= ST_IDLE;
         op_q       <= CMD_BIT;
         bit_q      <= 1'b1;
         cnt_q      <= 16'h0001;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
         own_bus_q  <= 1'b0;
         rx_bit_q   <= 1'b0;
         rxv_q      <= 1'b0;
         ready_q    <= 1'b0;
      end else begin
         st_q       <= st_d;
         op_q       <= op_d;
         bit_q      <= bit_d;
         cnt_q      <= cnt_d;
         scl_oe_n_q <= scl_oe_n_d;
         sda_oe_n_q <= sda_oe_n_d;
         own_bus_q  <= own_bus_d;
         rx_bit_q   <= rx_bit_d;
         rxv_q      <= rxv_d;
         ready_q    <= ready_d;
      end
   end

   // ---------------- outputs ----------------
   assign dat_o         = dat_q;
   assign ack_o         = ack_q;
   assign match_o       = match_q;
   assign match_valid_o = mval_q;
   assign cmd_ready_o   = ready_q;
   assign rx_valid_o    = rxv_q;
   assign rx_bit_o      = rx_bit_q;
   assign scl_oe_n_o    = scl_oe_n_q;
   assign sda_oe_n_o    = sda_oe_n_q;
   always_ff @(posedge clk_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
   end

   // ---------------- checks ----------------
   logic [15:0] ph_cnt_q;
   logic        rd_own_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_cnt_q <= 16'h0001;
         rd_own_q <= 1'b0;
      end else begin
         ph_cnt_q <= (st_d != st_q) ? 16'h0001 : ph_cnt_q + 16'h0001;
         rd_own_q <= ack_d && !we_i && (idx == `OWN_ADDR_IDX);
      end
   end

   sequence s_start_end;
      st_q == ST_START_HOLD && st_d != ST_START_HOLD;
   endsequence
   sequence s_clock_low_owned;
      !scl_oe_n_q && own_bus_q;
   endsequence

   property p_own_bit0;
      @(posedge clk_i) disable iff (rst_i)
      rd_own_q |-> ack_o && !dat_o[0];
   endproperty
   a_own_bit0: assert property (p_own_bit0)
      else $error("own address bit 0 read as one");

   property p_own_write;
      @(posedge clk_i) disable iff (rst_i)
      (ack_d && we_i && sel_i[0] && idx == `OWN_ADDR_IDX)
         |=> own_q == $past(dat_i[7:1]);
   endproperty
   a_own_write: assert property (p_own_write)
      else $error("own address not stored from bits 7..1");

   property p_match7;
      @(posedge clk_i) disable iff (rst_i)
      (cmp_req_i && !cmp_ten_bit_i)
         |=> match_valid_o && (match_o == ($past(cmp_addr_i) == own_q));
   endproperty
   a_match7: assert property (p_match7)
      else $error("7-bit address compare wrong");

   property p_match10;
      @(posedge clk_i) disable iff (rst_i)
      (cmp_req_i && cmp_ten_bit_i && !cmp_upper_ok_i) |=> !match_o;
   endproperty
   a_match10: assert property (p_match10)
      else $error("10-bit match without upper bits");

   property p_reset;
      @(posedge clk_i)
      rst_i |=> own_q == 7'h00 && rate_q == 8'h00 && scl_oe_n_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("registers not zero after reset");

   property p_scale;
      @(posedge clk_i) disable iff (rst_i)
      (rate_q[7:6] == 2'b10) |-> sda_c == {4'h0, sda_hold, 2'b00}
                                 && period_c == {2'b00, scl_div, 2'b00};
   endproperty
   a_scale: assert property (p_scale)
      else $error("scale x4 not applied");

   property p_sda_hold;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == ST_LOW_HOLD && st_d != ST_LOW_HOLD)
         |-> ph_cnt_q == sda_c && !scl_oe_n_q;
   endproperty
   a_sda_hold: assert property (p_sda_hold)
      else $error("data hold length wrong");

   property p_start;
      @(posedge clk_i) disable iff (rst_i)
      s_start_end |-> ph_cnt_q == start_c && scl_oe_n_q && !sda_oe_n_q
                  ##1 s_clock_low_owned;
   endproperty
   a_start: assert property (p_start)
      else $error("start hold wrong");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == ST_HIGH && st_d != ST_HIGH && op_q == CMD_STOP)
         |-> ph_cnt_q == stop_c && !sda_oe_n_q ##1 sda_oe_n_q && !own_bus_q;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop hold wrong");

   property p_table;
      @(posedge clk_i) disable iff (rst_i)
      $changed(rate_q[5:0]) |-> $changed(scl_div) && (sda_hold < scl_div[10:1]);
   endproperty
   a_table: assert property (p_table)
      else $error("rate index lookup inconsistent");

endmodule
`default_nettype wire

/* File: tb/i2c_bus_partner.sv */
// far-side bus devices: pull-ups, clock stretch and a data-low target
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
   // clock
   input  wire logic       clk_i,
   // controller pin enables
   input  wire logic       scl_oe_n_i,
   input  wire logic       sda_oe_n_i,
   // target behaviour
   input  wire logic       ack_i,
   input  wire logic [7:0] stretch_i,
   // wired lines
   output logic            scl_o,
   output logic            sda_o
);
   // starts released so the wired clock is known from the first edge
   logic [7:0] hold_q = 8'h00;
   // reload while the controller pulls low, count down after release
   always_ff @(posedge clk_i) begin
      if (!scl_oe_n_i)
         hold_q <= stretch_i;
      else if (hold_q != 8'h00)
         hold_q <= hold_q - 8'h01;
   end
   // pull-ups win unless someone drives low
   assign scl_o = scl_oe_n_i & (hold_q == 8'h00);
   assign sda_o = sda_oe_n_i & ~ack_i;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the own-address and bit-rate block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rate_map.svh"
module tb;
   import i2c_rate_pkg::*;
   logic        clk_i = 0, rst_i = 1;
   logic        cyc_i = 0, stb_i = 0, we_i = 0;
   logic [15:0] adr_i = 16'h0000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack_o, match_o, match_valid_o;
   logic        cmp_req_i = 0, cmp_ten_bit_i = 0, cmp_upper_ok_i = 0;
   logic [6:0]  cmp_addr_i = 7'h00, own;
   logic        cmd_valid_i = 0, cmd_bit_i = 0, cmd_ready_o;
   logic [1:0]  cmd_i = 2'h0;
   logic        rx_valid_o, rx_bit_o, rx_q, ack_n = 0;
   logic        scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, scl_w, sda_w;
   logic [7:0]  stretch = 8'h00;
   logic        scl_p = 1, sda_p = 1, sclw_p = 1, e10, uok;
   logic        last_m = 0;
   logic [31:0] seed = 32'hf08106f7;
   int cyc = 0, t_sdaf, t_sdar, t_sclf, t_sclf_p, t_sclr, err_total = 0;
   int compares = 0, s, i, dv, per, half, sdc, stc, spc, k;

   initial forever #4 clk_i = ~clk_i;

   i2c_own_address_and_bit_rate u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .cmp_req_i(cmp_req_i), .cmp_ten_bit_i(cmp_ten_bit_i),
      .cmp_upper_ok_i(cmp_upper_ok_i), .cmp_addr_i(cmp_addr_i),
      .match_o(match_o), .match_valid_o(match_valid_o),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_bit_i(cmd_bit_i),
      .cmd_ready_o(cmd_ready_o), .rx_valid_o(rx_valid_o),
      .rx_bit_o(rx_bit_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));

   i2c_bus_partner u_bus (.clk_i(clk_i), .scl_oe_n_i(scl_oe_n_o),
      .sda_oe_n_i(sda_oe_n_o), .ack_i(ack_n), .stretch_i(stretch),
      .scl_o(scl_w), .sda_o(sda_w));

   // edge timestamps of pin enables and the wired clock
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      scl_p <= scl_oe_n_o;
      sda_p <= sda_oe_n_o;
      sclw_p <= scl_w;
      if (sda_p && !sda_oe_n_o) t_sdaf <= cyc;
      if (!sda_p && sda_oe_n_o) t_sdar <= cyc;
      if (scl_p && !scl_oe_n_o) begin
         t_sclf <= cyc;
         t_sclf_p <= t_sclf;
      end
      if (!sclw_p && scl_w) t_sclr <= cyc;
      if (rx_valid_o === 1'b1) rx_q <= rx_bit_o;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic stop_test();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_rng(input string n, input int lo, input int hi,
                          input int g);
      compares++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask

   task automatic wb(input logic w, input logic [13:0] idx,
                     input logic [7:0] d, input logic [3:0] sl);
      int n;
      cyc_i <= 1; stb_i <= 1; we_i <= w;
      adr_i <= {idx, 2'b00}; dat_i <= {24'h0, d}; sel_i <= sl;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) begin
         err_total++;
         stop_test();
      end
      q = dat_o;
      cyc_i <= 0; stb_i <= 0;
      @(posedge clk_i);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 5000) begin
         @(posedge clk_i);
         n++;
      end
      if (cmd_ready_o !== 1'b1) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic cmd(input logic [1:0] c, input logic b);
      wait_ready();
      cmd_valid_i <= 1; cmd_i <= c; cmd_bit_i <= b;
      @(posedge clk_i);
      cmd_valid_i <= 0;
      repeat (2) @(posedge clk_i);
      wait_ready();
      // let the edge stamps taken at the final edge settle
      @(posedge clk_i);
   endtask

   task automatic compare(input logic [6:0] a, input logic t,
                          input logic u);
      cmp_req_i <= 1; cmp_addr_i <= a; cmp_ten_bit_i <= t;
      cmp_upper_ok_i <= u;
      @(posedge clk_i);
      cmp_req_i <= 0;
      @(posedge clk_i);
      last_m = (a == own) && (!t || u);
      chk("match_valid", 32'h1, {31'h0, match_valid_o});
      chk("match", {31'h0, last_m}, {31'h0, match_o});
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      repeat (3) @(posedge clk_i);
      wb(0, `OWN_ADDR_IDX, 8'h00, 4'h1);
      chk("own reset", 32'h0, q);
      wb(0, `RATE_DIV_IDX, 8'h00, 4'h1);
      chk("div reset", 32'h0, q);
      own = 7'(rnd());
      wb(1, `OWN_ADDR_IDX, {own, 1'b1}, 4'h1);
      wb(1, `OWN_ADDR_IDX, 8'hff, 4'h0);
      wb(0, `OWN_ADDR_IDX, 8'h00, 4'h1);
      chk("own read", {24'h0, own, 1'b0}, q);
      wb(1, 14'h3075, 8'h5a, 4'h1);
      wb(0, 14'h3075, 8'h00, 4'h1);
      chk("unmapped", 32'h0, q);
      for (k = 0; k < 8; k++) begin
         e10 = 1'(rnd());
         uok = 1'(rnd());
         compare((k % 2) ? own : 7'(rnd()), e10, uok);
      end
      wb(0, `LINE_STAT_IDX, 8'h00, 4'h1);
      chk("stat match", {31'h0, last_m}, {31'h0, q[`STAT_MATCH_BIT]});
      for (s = 0; s < 3; s++) begin
         i = rnd() % 4;
         dv = 20 + 8 * i;
         per = dv << s;
         half = per / 2;
         sdc = (7 + i) << s;
         stc = (dv / 2 - 4) << s;
         spc = (dv / 2 + 1) << s;
         wb(1, `RATE_DIV_IDX, {2'(s), 6'(i)}, 4'h1);
         wb(0, `RATE_DIV_IDX, 8'h00, 4'h1);
         chk("div read", {24'h0, 2'(s), 6'(i)}, q);
         cmd(CMD_START, 0);
         chk_rng("start hold", stc, stc, t_sclf - t_sdaf);
         cmd(CMD_BIT, 1);
         chk_rng("sda hold", sdc, sdc + 4, t_sdar - t_sclf_p);
         chk("rx one", 32'h1, {31'h0, rx_q});
         cmd(CMD_BIT, 0);
         chk_rng("bit period", per, per + 8, t_sclf - t_sclf_p);
         chk_rng("sda hold0", sdc, sdc + 4, t_sdaf - t_sclf_p);
         ack_n <= 1;
         stretch <= 8'h0c;
         cmd(CMD_BIT, 1);
         chk_rng("stretched", half, half + 5, t_sclf - t_sclr);
         chk("rx ack", 32'h0, {31'h0, rx_q});
         ack_n <= 0;
         stretch <= 8'h00;
         wb(0, `LINE_STAT_IDX, 8'h00, 4'h1);
         chk("owned", 32'h1, {31'h0, q[`STAT_OWN_BIT]});
         chk("stat rx", 32'h0, {31'h0, q[`STAT_RX_BIT]});
         chk("stat busy", 32'h0, {31'h0, q[`STAT_BUSY_BIT]});
         cmd(CMD_START, 0);
         chk_rng("rstart hold", stc, stc, t_sclf - t_sdaf);
         cmd(CMD_STOP, 0);
         chk_rng("stop hold", spc, spc + 5, t_sdar - t_sclr);
         wb(0, `LINE_STAT_IDX, 8'h00, 4'h1);
         chk("released", 32'h0, {31'h0, q[`STAT_OWN_BIT]});
         chk("pin data", 32'h0, {30'h0, scl_o, sda_o});
      end
      stop_test();
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
